// File: rtl/i2cms_pkg.sv
// Constants, states and state record of the two-wire master sequencer
package i2cms_pkg;
    // Byte offsets of the Avalon registers, one aligned word each
    localparam logic [4:0] ADR_CTRL = 5'h00;
    localparam logic [4:0] ADR_STAT = 5'h04;
    localparam logic [4:0] ADR_RELOAD = 5'h08;
    localparam logic [4:0] ADR_BUF = 5'h0c;
    localparam logic [4:0] ADR_FLAG = 5'h10;
    // bus_control_two fields
    localparam int B_START = 0;
    localparam int B_RESTART = 1;
    localparam int B_RECV = 3;
    localparam int B_ACKRX = 6;
    // port_status_reg fields
    localparam int B_FULL = 0;
    localparam int B_SSEEN = 3;
    // Event flag register fields, write one to clear
    localparam int B_EVT = 0;
    localparam int B_BCOL = 1;
    localparam int B_WRITE_COLLISION = 2;
    localparam int B_OVF = 3;
    localparam int RELOAD_W = 7;
    localparam logic [RELOAD_W-1:0] RELOAD_RST = 7'h00;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [23:0] RD_PAD = 24'h000000;

    typedef enum logic [3:0] {
        IDLE = 4'h0,
        ST_WAIT = 4'h1,
        ST_HOLD = 4'h2,
        RS_LOW = 4'h3,
        RS_SDA = 4'h4,
        RS_REL = 4'h5,
        RS_HIGH = 4'h6,
        RS_SDAL = 4'h7,
        TX_LOW = 4'h8,
        TX_REL = 4'h9,
        TX_HIGH = 4'ha,
        RX_LOW = 4'hb,
        RX_REL = 4'hc,
        RX_HIGH = 4'hd
    } i2cms_state_t;

    typedef struct packed {
        i2cms_state_t state;
        logic [RELOAD_W-1:0] cnt;
        logic [3:0] bits;
        logic [7:0] shreg;
        logic [7:0] buffer;
        logic [RELOAD_W-1:0] reload;
        logic start_req;
        logic restart_req;
        logic recv_req;
        logic ack_rx;
        logic full;
        logic sseen;
        logic evt;
        logic bcol;
        logic write_collision;
        logic ovf;
        logic scl_low;
        logic sda_low;
        logic scl_m;
        logic scl_s;
        logic sda_m;
        logic sda_s;
        logic waitreq;
        logic [7:0] rdata;
    } i2cms_regs_t;
endpackage : i2cms_pkg

// File: rtl/i2cms_seq.sv
// Two-wire bus master sequencer with Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none

module i2cms_seq (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [4:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE
);
    i2cms_pkg::i2cms_regs_t r;
    i2cms_pkg::i2cms_regs_t n;
    logic wr_ok;
    logic rd_ok;
    logic idle_free;
    logic expired;

    // Counting states: the counter steps down once every CLK period
    function automatic logic i2cms_counting(input i2cms_pkg::i2cms_state_t s);
        return s inside {i2cms_pkg::ST_WAIT, i2cms_pkg::ST_HOLD, i2cms_pkg::RS_SDA,
            i2cms_pkg::RS_HIGH, i2cms_pkg::RS_SDAL, i2cms_pkg::TX_LOW,
            i2cms_pkg::TX_HIGH, i2cms_pkg::RX_LOW, i2cms_pkg::RX_HIGH};
    endfunction : i2cms_counting

    function automatic logic i2cms_in_start(input i2cms_pkg::i2cms_state_t s);
        return s inside {i2cms_pkg::ST_WAIT, i2cms_pkg::ST_HOLD, i2cms_pkg::RS_LOW,
            i2cms_pkg::RS_SDA, i2cms_pkg::RS_REL, i2cms_pkg::RS_HIGH, i2cms_pkg::RS_SDAL};
    endfunction : i2cms_in_start

    // Write takes effect on the edge where the master sees waitrequest low
    assign wr_ok = WRITE && !r.waitreq;
    assign rd_ok = READ && !r.waitreq;
    // No queueing: a pending request counts as busy
    assign idle_free = (r.state == i2cms_pkg::IDLE) && !r.start_req
        && !r.restart_req && !r.recv_req;
    assign expired = (r.cnt == '0);

    assign READDATA = {i2cms_pkg::RD_PAD, r.rdata};
    assign WAITREQUEST = r.waitreq;
    assign SCL_O = 1'b0;
    assign SDA_O = 1'b0;
    assign SCL_OE = r.scl_low;
    assign SDA_OE = r.sda_low;

    always_comb
    begin
        n = r;
        n.scl_m = SCL_I;
        n.scl_s = r.scl_m;
        n.sda_m = SDA_I;
        n.sda_s = r.sda_m;
        // One wait cycle, then one answer cycle
        n.waitreq = !(r.waitreq && (READ || WRITE));
        if (r.waitreq && READ)
        begin
            case (ADDRESS)
                i2cms_pkg::ADR_CTRL: n.rdata = {1'b0, r.ack_rx, 2'b00, r.recv_req,
                    1'b0, r.restart_req, r.start_req};
                i2cms_pkg::ADR_STAT: n.rdata = {4'h0, r.sseen, 2'b00, r.full};
                i2cms_pkg::ADR_RELOAD: n.rdata = {1'b0, r.reload};
                i2cms_pkg::ADR_BUF: n.rdata = r.buffer;
                i2cms_pkg::ADR_FLAG: n.rdata = {4'h0, r.ovf, r.write_collision, r.bcol, r.evt};
                default: n.rdata = 8'h00;
            endcase
        end
        // A read during transmit must not drop the full flag early
        if (rd_ok && ADDRESS == i2cms_pkg::ADR_BUF
            && !(r.state inside {i2cms_pkg::TX_LOW, i2cms_pkg::TX_REL, i2cms_pkg::TX_HIGH}))
        begin
            n.full = 1'b0;
        end
        if (wr_ok)
        begin
            case (ADDRESS)
                i2cms_pkg::ADR_CTRL:
                begin
                    // Request bits only accepted while fully idle
                    if (idle_free)
                    begin
                        n.start_req = WRITEDATA[i2cms_pkg::B_START];
                        n.restart_req = WRITEDATA[i2cms_pkg::B_RESTART];
                        n.recv_req = WRITEDATA[i2cms_pkg::B_RECV];
                    end
                end
                i2cms_pkg::ADR_STAT:
                begin
                    if (WRITEDATA[i2cms_pkg::B_SSEEN])
                        n.sseen = 1'b0;
                end
                i2cms_pkg::ADR_RELOAD: n.reload = WRITEDATA[i2cms_pkg::RELOAD_W-1:0];
                i2cms_pkg::ADR_BUF:
                begin
                    if (idle_free)
                    begin
                        n.buffer = WRITEDATA[7:0];
                        n.shreg = WRITEDATA[7:0];
                        n.full = 1'b1;
                        n.bits = 4'h0;
                        n.scl_low = 1'b1;
                        n.cnt = r.reload;
                        n.state = i2cms_pkg::TX_LOW;
                    end
                    else
                    begin
                        n.write_collision = 1'b1;
                    end
                end
                i2cms_pkg::ADR_FLAG:
                begin
                    // Clears first; hardware sets below win
                    if (WRITEDATA[i2cms_pkg::B_EVT])
                        n.evt = 1'b0;
                    if (WRITEDATA[i2cms_pkg::B_BCOL])
                        n.bcol = 1'b0;
                    if (WRITEDATA[i2cms_pkg::B_WRITE_COLLISION])
                        n.write_collision = 1'b0;
                    if (WRITEDATA[i2cms_pkg::B_OVF])
                        n.ovf = 1'b0;
                end
                default:
                begin
                end
            endcase
        end
        if (i2cms_counting(r.state) && !expired)
            n.cnt = r.cnt - 1'b1;
        case (r.state)
            i2cms_pkg::IDLE:
            begin
                if (r.start_req)
                begin
                    if (r.scl_s && r.sda_s)
                    begin
                        n.cnt = r.reload;
                        n.state = i2cms_pkg::ST_WAIT;
                    end
                    else
                    begin
                        n.start_req = 1'b0;
                        n.bcol = 1'b1;
                        n.sda_low = 1'b0;
                    end
                end
                else if (r.restart_req)
                begin
                    n.scl_low = 1'b1;
                    n.state = i2cms_pkg::RS_LOW;
                end
                else if (r.recv_req)
                begin
                    n.scl_low = 1'b1;
                    n.sda_low = 1'b0;
                    n.bits = 4'h0;
                    n.cnt = r.reload;
                    n.state = i2cms_pkg::RX_LOW;
                end
            end
            i2cms_pkg::ST_WAIT:
            begin
                if (!r.scl_s || (expired && !r.sda_s))
                begin
                    n.start_req = 1'b0;
                    n.bcol = 1'b1;
                    n.sda_low = 1'b0;
                    n.state = i2cms_pkg::IDLE;
                end
                else if (expired)
                begin
                    n.sda_low = 1'b1;
                    n.sseen = 1'b1;
                    n.cnt = r.reload;
                    n.state = i2cms_pkg::ST_HOLD;
                end
            end
            i2cms_pkg::ST_HOLD:
            begin
                // Another master pulling SCL here is no collision
                if (expired)
                begin
                    n.start_req = 1'b0;
                    n.evt = 1'b1;
                    n.state = i2cms_pkg::IDLE;
                end
            end
            i2cms_pkg::RS_LOW:
            begin
                if (!r.scl_s)
                begin
                    n.cnt = {1'b0, r.reload[5:0]};
                    n.sda_low = 1'b0;
                    n.state = i2cms_pkg::RS_SDA;
                end
            end
            i2cms_pkg::RS_SDA:
            begin
                if (expired)
                begin
                    if (r.sda_s)
                    begin
                        n.scl_low = 1'b0;
                        n.state = i2cms_pkg::RS_REL;
                    end
                    else
                    begin
                        n.restart_req = 1'b0;
                        n.bcol = 1'b1;
                        n.scl_low = 1'b0;
                        n.state = i2cms_pkg::IDLE;
                    end
                end
            end
            i2cms_pkg::RS_REL:
            begin
                if (r.scl_s && !r.sda_s)
                begin
                    n.restart_req = 1'b0;
                    n.bcol = 1'b1;
                    n.state = i2cms_pkg::IDLE;
                end
                else if (r.scl_s)
                begin
                    n.cnt = r.reload;
                    n.state = i2cms_pkg::RS_HIGH;
                end
            end
            i2cms_pkg::RS_HIGH:
            begin
                if (!r.scl_s || !r.sda_s)
                begin
                    n.restart_req = 1'b0;
                    n.bcol = 1'b1;
                    n.state = i2cms_pkg::IDLE;
                end
                else if (expired)
                begin
                    n.sda_low = 1'b1;
                    n.sseen = 1'b1;
                    n.cnt = r.reload;
                    n.state = i2cms_pkg::RS_SDAL;
                end
            end
            i2cms_pkg::RS_SDAL:
            begin
                if (expired)
                begin
                    n.restart_req = 1'b0;
                    n.evt = 1'b1;
                    n.state = i2cms_pkg::IDLE;
                end
            end
            i2cms_pkg::TX_LOW:
            begin
                // Bit goes out only once SCL is seen low, for hold time
                if (!r.scl_s)
                    n.sda_low = (r.bits != i2cms_pkg::ACK_BIT) && !r.shreg[7];
                if (expired)
                begin
                    n.scl_low = 1'b0;
                    n.state = i2cms_pkg::TX_REL;
                end
            end
            i2cms_pkg::TX_REL:
            begin
                if (r.scl_s)
                begin
                    n.cnt = r.reload;
                    n.state = i2cms_pkg::TX_HIGH;
                end
            end
            i2cms_pkg::TX_HIGH:
            begin
                if (expired)
                begin
                    n.scl_low = 1'b1;
                    if (r.bits == i2cms_pkg::ACK_BIT)
                    begin
                        n.ack_rx = r.sda_s;
                        n.evt = 1'b1;
                        n.state = i2cms_pkg::IDLE;
                    end
                    else
                    begin
                        n.shreg = {r.shreg[6:0], 1'b0};
                        n.bits = r.bits + 4'h1;
                        if (r.bits == i2cms_pkg::LAST_BIT)
                            n.full = 1'b0;
                        n.cnt = r.reload;
                        n.state = i2cms_pkg::TX_LOW;
                    end
                end
            end
            i2cms_pkg::RX_LOW:
            begin
                if (expired)
                begin
                    n.scl_low = 1'b0;
                    n.state = i2cms_pkg::RX_REL;
                end
            end
            i2cms_pkg::RX_REL:
            begin
                if (r.scl_s)
                begin
                    n.cnt = r.reload;
                    n.shreg = {r.shreg[6:0], r.sda_s};
                    n.state = i2cms_pkg::RX_HIGH;
                end
            end
            i2cms_pkg::RX_HIGH:
            begin
                if (expired)
                begin
                    n.scl_low = 1'b1;
                    if (r.bits == i2cms_pkg::LAST_BIT)
                    begin
                        n.recv_req = 1'b0;
                        n.buffer = r.shreg;
                        n.ovf = r.ovf || r.full;
                        n.full = 1'b1;
                        n.evt = 1'b1;
                        n.state = i2cms_pkg::IDLE;
                    end
                    else
                    begin
                        n.bits = r.bits + 4'h1;
                        n.cnt = r.reload;
                        n.state = i2cms_pkg::RX_LOW;
                    end
                end
            end
            default: n.state = i2cms_pkg::IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            r <= '0;
            r.reload <= i2cms_pkg::RELOAD_RST;
            r.scl_m <= 1'b1;
            r.scl_s <= 1'b1;
            r.sda_m <= 1'b1;
            r.sda_s <= 1'b1;
            r.waitreq <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    sequence s_start_fire;
        r.state == i2cms_pkg::ST_WAIT && expired && r.scl_s && r.sda_s;
    endsequence
    sequence s_rx_last;
        r.state == i2cms_pkg::RX_HIGH && expired && r.bits == i2cms_pkg::LAST_BIT;
    endsequence
    sequence s_tx_ack;
        r.state == i2cms_pkg::TX_HIGH && expired && r.bits == i2cms_pkg::ACK_BIT;
    endsequence

    a_start_coll: assert property (r.state == i2cms_pkg::IDLE && r.start_req
        && !(r.scl_s && r.sda_s) |=> r.bcol && !r.start_req && !r.sda_low)
        else $error("start collision not flagged");
    a_start_cond: assert property (s_start_fire |=> r.sda_low && r.sseen
        && r.state == i2cms_pkg::ST_HOLD ##1 r.scl_low == 1'b0)
        else $error("start condition not formed");
    a_start_end: assert property (r.state == i2cms_pkg::ST_HOLD && expired
        |=> !r.start_req && r.sda_low && r.evt && r.state == i2cms_pkg::IDLE)
        else $error("start end wrong");
    a_write_collision_set: assert property (wr_ok && ADDRESS == i2cms_pkg::ADR_BUF
        && !idle_free |=> r.write_collision && $stable(r.buffer))
        else $error("write collision missed");
    a_ctrl_lock: assert property (wr_ok && ADDRESS == i2cms_pkg::ADR_CTRL
        && i2cms_in_start(r.state) && !r.recv_req |=> !r.recv_req)
        else $error("control write not locked");
    a_rs_ignore: assert property (wr_ok && ADDRESS == i2cms_pkg::ADR_CTRL
        && r.state != i2cms_pkg::IDLE && !r.restart_req |=> !r.restart_req)
        else $error("restart accepted while busy");
    a_tx_begin: assert property (wr_ok && ADDRESS == i2cms_pkg::ADR_BUF
        && idle_free |=> r.full && r.scl_low && r.state == i2cms_pkg::TX_LOW)
        else $error("transmit did not begin");
    a_ack_take: assert property (s_tx_ack |=> r.ack_rx == $past(r.sda_s)
        && r.evt && r.scl_low && r.state == i2cms_pkg::IDLE ##1 r.scl_low)
        else $error("acknowledge handling wrong");
    a_rx_done: assert property (s_rx_last |=> r.full && r.evt && !r.recv_req
        && r.buffer == $past(r.shreg) && r.scl_low)
        else $error("receive completion wrong");
    a_rx_ovf: assert property (s_rx_last ##0 r.full |=> r.ovf)
        else $error("overflow not flagged");
    a_scl_wait: assert property (r.state == i2cms_pkg::TX_REL && r.scl_s
        |=> r.state == i2cms_pkg::TX_HIGH && r.cnt == $past(r.reload))
        else $error("counter not reloaded on SCL high");
    a_cnt_step: assert property (i2cms_counting(r.state) && !expired
        |=> r.cnt == $past(r.cnt) - 1'b1)
        else $error("counter did not step");
endmodule : i2cms_seq

`default_nettype wire

// File: bench/i2cms_slave.sv
// Bus slave model: pull-ups, clock stretching, acknowledge and read data
`timescale 1ns/100ps
`default_nettype none
module i2cms_slave (
    input wire logic clk,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic ack_on,
    input wire logic rd_mode,
    input wire logic [7:0] rd_byte,
    input wire logic [3:0] stretch,
    input wire logic jam_sda,
    input wire logic sync,
    output logic scl,
    output logic sda,
    output logic [7:0] got
);
    logic scl_q = 1'h1;
    logic oe_q = 1'h0;
    logic ack_q = 1'h0;
    logic rx_q = 1'h0;
    logic [3:0] rises = 4'h0;
    logic [3:0] st_cnt = 4'h0;
    // Released lines float high through the pull-ups
    // Delayed enable bridges the gap before the stretch count loads
    assign scl = !(scl_oe || oe_q || st_cnt != 4'h0);
    assign sda = !(sda_oe || ack_q || rx_q || jam_sda);
    always_ff @(posedge clk)
    begin
        scl_q <= scl;
        oe_q <= scl_oe;
        // Hold SCL low after each release so the master must wait
        if (oe_q && !scl_oe)
            st_cnt <= stretch;
        else if (st_cnt != 4'h0)
            st_cnt <= st_cnt - 4'h1;
        if (sync)
        begin
            rises <= 4'h0;
            rx_q <= rd_mode && !rd_byte[7];
        end
        else if (scl && !scl_q)
        begin
            rises <= rises + 4'h1;
            if (rises < 4'h8)
                got <= {got[6:0], sda};
        end
        else if (!scl && scl_q)
        begin
            // Data changes only while SCL is low
            ack_q <= ack_on && !rd_mode && rises == 4'h8;
            rx_q <= rd_mode && rises < 4'h8 && !rd_byte[3'h7 - rises[2:0]];
        end
    end
endmodule : i2cms_slave
`default_nettype wire

// File: bench/i2c_master_sequencer_tb_top.sv
// Self-checking bench for the two-wire master sequencer
`timescale 1ns/100ps
`default_nettype none
module i2c_master_sequencer_tb_top;
    typedef struct packed {
        logic wr;
        logic [4:0] adr;
        logic [31:0] wd;
        logic [31:0] ex;
    } i2cms_row_t;
    localparam logic [4:0] A_CTL = i2cms_pkg::ADR_CTRL;
    localparam logic [4:0] A_STA = i2cms_pkg::ADR_STAT;
    localparam logic [4:0] A_RLD = i2cms_pkg::ADR_RELOAD;
    localparam logic [4:0] A_BUF = i2cms_pkg::ADR_BUF;
    localparam logic [4:0] A_FLG = i2cms_pkg::ADR_FLAG;
    localparam logic [31:0] C_ST = 32'h1 << i2cms_pkg::B_START;
    localparam logic [31:0] C_RS = 32'h1 << i2cms_pkg::B_RESTART;
    localparam logic [31:0] C_RX = 32'h1 << i2cms_pkg::B_RECV;
    localparam logic [31:0] C_AK = 32'h1 << i2cms_pkg::B_ACKRX;
    localparam logic [31:0] S_BF = 32'h1 << i2cms_pkg::B_FULL;
    localparam logic [31:0] S_SS = 32'h1 << i2cms_pkg::B_SSEEN;
    localparam logic [31:0] F_EV = 32'h1 << i2cms_pkg::B_EVT;
    localparam logic [31:0] F_BC = 32'h1 << i2cms_pkg::B_BCOL;
    localparam logic [31:0] F_WC = 32'h1 << i2cms_pkg::B_WRITE_COLLISION;
    localparam logic [31:0] F_OV = 32'h1 << i2cms_pkg::B_OVF;
    localparam int NROW = 8;
    // Reload 3 gives 4-cycle rollovers, 64 ns of counted SCL low and high time per period
    i2cms_row_t rows [NROW] = '{'{1'h0, A_CTL, 32'h0, 32'h0}, '{1'h0, A_STA, 32'h0, 32'h0},
        '{1'h0, A_RLD, 32'h0, 32'h0}, '{1'h0, A_BUF, 32'h0, 32'h0},
        '{1'h0, A_FLG, 32'h0, 32'h0}, '{1'h1, 5'h14, 32'hff, 32'h0},
        '{1'h1, A_RLD, 32'hff, 32'h7f}, '{1'h1, A_RLD, 32'h0f, 32'h0f}};
    logic CLK = 1'h0;
    logic RESETN = 1'h0;
    logic [4:0] ADDRESS = 5'h00;
    logic READ = 1'h0;
    logic WRITE = 1'h0;
    logic [31:0] WRITEDATA = 32'h0;
    logic [31:0] READDATA, rd;
    logic WAITREQUEST, SCL_O, SCL_OE, SDA_O, SDA_OE, scl, sda;
    logic ack_on = 1'h0;
    logic rd_mode = 1'h0;
    logic jam_sda = 1'h0;
    logic sync = 1'h0;
    logic [7:0] rd_byte = 8'h00;
    logic [7:0] got;
    logic [3:0] stretch = 4'h6;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    always #4 CLK = ~CLK;
    i2cms_seq u_dut (.CLK(CLK), .RESETN(RESETN), .ADDRESS(ADDRESS), .READ(READ),
        .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST), .SCL_I(scl), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
        .SDA_I(sda), .SDA_O(SDA_O), .SDA_OE(SDA_OE));
    i2cms_slave u_slave (.clk(CLK), .scl_oe(SCL_OE), .sda_oe(SDA_OE), .ack_on(ack_on),
        .rd_mode(rd_mode), .rd_byte(rd_byte), .stretch(stretch), .jam_sda(jam_sda),
        .sync(sync), .scl(scl), .sda(sda), .got(got));
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] seen);
        checks++;
        if (seen !== ex)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
            n_errors++;
        end
    endtask : chk
    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDRESS <= a;
        WRITEDATA <= d;
        WRITE <= w;
        READ <= !w;
        // Only the cycle ceiling ends a hung wait
        do
        begin
            @(posedge CLK);
        end
        while (WAITREQUEST !== 1'h0);
        rd = READDATA;
        WRITE <= 1'h0;
        READ <= 1'h0;
    endtask : bus
    task automatic put(input logic [4:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask : put
    task automatic rchk(input logic [4:0] a, input logic [31:0] ex, input string nm);
        bus(1'h0, a, 32'h0);
        chk(nm, ex, rd);
    endtask : rchk
    task automatic lchk(input string nm, input logic ex, input logic seen);
        chk(nm, {31'h0, ex}, {31'h0, seen});
    endtask : lchk
    task automatic wait_evt;
        int n;
        n = 0;
        do
        begin
            bus(1'h0, A_FLG, 32'h0);
            n++;
        end
        while ((rd[i2cms_pkg::B_EVT] | rd[i2cms_pkg::B_BCOL]) !== 1'h1 && n < 300);
    endtask : wait_evt
    task automatic prep(input logic ak, input logic rm, input logic [7:0] b);
        @(posedge CLK);
        ack_on <= ak;
        rd_mode <= rm;
        rd_byte <= b;
        sync <= 1'h1;
        @(posedge CLK);
        sync <= 1'h0;
    endtask : prep
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (12) @(posedge CLK);
        lchk("waitreq", 1'h1, WAITREQUEST);
        lchk("scl_oe", 1'h0, SCL_OE);
        lchk("sda_oe", 1'h0, SDA_OE);
        lchk("scl_o", 1'h0, SCL_O);
        lchk("sda_o", 1'h0, SDA_O);
        RESETN <= 1'h1;
        for (int i = 0; i < NROW; i++)
        begin
            if (rows[i].wr)
                put(rows[i].adr, rows[i].wd);
            rchk(rows[i].adr, rows[i].ex, "row");
        end
        // Start while another party holds SDA low
        jam_sda <= 1'h1;
        put(A_CTL, C_ST);
        wait_evt();
        rchk(A_FLG, F_BC, "flag");
        rchk(A_CTL, 32'h0, "ctrl");
        jam_sda <= 1'h0;
        put(A_FLG, 32'hf);
        // Start with a buffer write and a restart issued during it, both refused
        put(A_CTL, C_ST);
        put(A_BUF, 32'h55);
        put(A_CTL, C_RS);
        wait_evt();
        rchk(A_FLG, F_EV | F_WC, "flag");
        rchk(A_STA, S_SS, "stat");
        rchk(A_CTL, 32'h0, "ctrl");
        rchk(A_BUF, 32'h0, "buf");
        lchk("sda", 1'h0, sda);
        lchk("scl", 1'h1, scl);
        put(A_FLG, 32'hf);
        put(A_STA, S_SS);
        put(A_RLD, 32'h3);
        put(A_CTL, C_RS);
        wait_evt();
        rchk(A_STA, S_SS, "stat");
        rchk(A_CTL, 32'h0, "ctrl");
        lchk("sda", 1'h0, sda);
        lchk("scl", 1'h1, scl);
        put(A_FLG, 32'hf);
        put(A_STA, S_SS);
        // Acknowledged byte, slave holding SCL low after every release
        prep(1'h1, 1'h0, 8'h00);
        put(A_BUF, 32'ha5);
        rchk(A_STA, S_BF, "full");
        wait_evt();
        chk("byte", 32'ha5, {24'h0, got});
        rchk(A_CTL, 32'h0, "ack");
        rchk(A_STA, 32'h0, "full");
        lchk("scl_oe", 1'h1, SCL_OE);
        put(A_FLG, 32'hf);
        // Refused byte with a second buffer write mid-byte
        prep(1'h0, 1'h0, 8'h00);
        put(A_BUF, 32'h3c);
        put(A_BUF, 32'hff);
        wait_evt();
        chk("byte", 32'h3c, {24'h0, got});
        rchk(A_CTL, C_AK, "ack");
        rchk(A_FLG, F_EV | F_WC, "flag");
        put(A_FLG, 32'hf);
        // Two bytes received, the second while the first is unread
        prep(1'h0, 1'h1, 8'h96);
        put(A_CTL, C_RX);
        wait_evt();
        rchk(A_CTL, C_AK, "ctrl");
        put(A_FLG, 32'hf);
        prep(1'h0, 1'h1, 8'h69);
        put(A_CTL, C_RX);
        put(A_BUF, 32'h11);
        wait_evt();
        rchk(A_FLG, F_EV | F_WC | F_OV, "flag");
        rchk(A_STA, S_BF, "full");
        rchk(A_BUF, 32'h69, "buf");
        rchk(A_STA, 32'h0, "full");
        lchk("scl_oe", 1'h1, SCL_OE);
        put(A_FLG, 32'hf);
        // Restart while another master holds SDA low
        jam_sda <= 1'h1;
        put(A_CTL, C_RS);
        wait_evt();
        rchk(A_FLG, F_BC, "flag");
        wrap_up();
    end
endmodule : i2c_master_sequencer_tb_top
`default_nettype wire
